// [rtl/fpc_cfg.svh]
`ifndef FPC_CFG_SVH
`define FPC_CFG_SVH

// Register byte addresses; the control and address registers add 0x4/0x8/0xC aliases.
`define FPC_ADDR_W 16
`define FPC_OFF_CONTROL 16'hF400
`define FPC_OFF_KEY 16'hF410
`define FPC_OFF_TARGET 16'hF420
`define FPC_OFF_DATA 16'hF430
`define FPC_OFF_SOURCE 16'hF440
`define FPC_ALIAS_CLR 2'h1
`define FPC_ALIAS_SET 2'h2
`define FPC_ALIAS_INV 2'h3

// Control register field positions.
`define FPC_BIT_TRIGGER 15
`define FPC_BIT_ARM 14
`define FPC_BIT_OPFAULT 13
`define FPC_BIT_UVFAULT 12
`define FPC_BIT_UVLIVE 11
`define FPC_OPSEL_MSB 3
`define FPC_CONTROL_RESET 32'h0000_0000

// Operation codes.
`define FPC_OP_NONE 4'h0
`define FPC_OP_WORD 4'h1
`define FPC_OP_ROW 4'h3
`define FPC_OP_PAGE 4'h4
`define FPC_OP_ARRAY 4'h5

// Unlock key words; the values are arbitrary.
`define FPC_KEY_FIRST 32'h1234_5678
`define FPC_KEY_SECOND 32'h8765_4321

// Geometry: page is 4 KB (1024 words), row is 512 bytes (128 words).
`define FPC_PAGE_LOG2 12
`define FPC_ROW_LOG2 9
`define FPC_WORD_LOG2 2

`endif

// [rtl/fpc_pkg.sv]
package fpc_pkg;

    typedef enum logic [1:0] {
        FSM_IDLE,
        FSM_RUN,
        FSM_FINISH
    } fpc_fsm_e;

    typedef enum logic [1:0] {
        UNL_NONE,
        UNL_FIRST,
        UNL_READY
    } fpc_unlock_e;

    // Command handed to the flash array engine.
    typedef struct packed {
        logic req;
        logic [3:0] op;
        logic [31:0] addr;
        logic [31:0] data;
        logic [31:0] src;
    } fpc_cmd_s;

    // APB answer.
    typedef struct packed {
        logic ready;
        logic slverr;
        logic [31:0] rdata;
    } fpc_apb_rsp_s;

    typedef struct packed {
        fpc_fsm_e fsm;
        fpc_unlock_e unlock;
        logic trigger;
        logic op_fault;
        logic uv_fault;
        logic uv_live;
        logic [3:0] op_sel;
        logic [31:0] target;
        logic [31:0] pdata;
        logic [31:0] source;
        fpc_cmd_s cmd;
        fpc_apb_rsp_s rsp;
    } fpc_state_s;

endpackage : fpc_pkg

// [rtl/fpc_top.sv]
// Chosen here: the APB register port.
`timescale 1ns/1ns
`include "fpc_cfg.svh"
module fpc_top (
    // Clock and resets
    input wire logic CLK,
    input wire logic RSTN,
    input wire logic POR_N,
    // APB slave
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [15:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic PREADY,
    output logic PSLVERR,
    output logic [31:0] PRDATA,
    // Flash array engine
    output fpc_pkg::fpc_cmd_s FL_CMD,
    input wire logic FL_DONE,
    input wire logic FL_FAIL,
    // Write protection of the addressed region and of any page
    input wire logic WP_TARGET,
    input wire logic WP_ANY,
    // Undervoltage detector and busy flag
    input wire logic UV_DETECT,
    output logic UV_DETECT_EN,
    output logic BUSY
);

    ////////////////////////////////////////////////////////////////////////////////
    // Functions

    // Aligns the target address to the unit that the operation touches.
    function automatic logic [31:0] fpc_align(input logic [3:0] op, input logic [31:0] a);
        logic [31:0] r;
        r = a;
        unique case (op)
            `FPC_OP_ARRAY: r = 32'h0000_0000;
            `FPC_OP_PAGE: r = {a[31:`FPC_PAGE_LOG2], {`FPC_PAGE_LOG2{1'b0}}};
            `FPC_OP_ROW: r = {a[31:`FPC_ROW_LOG2], {`FPC_ROW_LOG2{1'b0}}};
            default: r = {a[31:`FPC_WORD_LOG2], {`FPC_WORD_LOG2{1'b0}}};
        endcase
        return r;
    endfunction : fpc_align

    // Applies a plain, clear, set or invert alias write.
    function automatic logic [31:0] fpc_alias(input logic [1:0] k, input logic [31:0] old,
                                              input logic [31:0] w);
        logic [31:0] r;
        r = w;
        unique case (k)
            `FPC_ALIAS_CLR: r = old & ~w;
            `FPC_ALIAS_SET: r = old | w;
            `FPC_ALIAS_INV: r = old ^ w;
            default: r = w;
        endcase
        return r;
    endfunction : fpc_alias

    function automatic logic fpc_is_flash_op(input logic [3:0] op);
        return (op == `FPC_OP_WORD) || (op == `FPC_OP_ROW) ||
               (op == `FPC_OP_PAGE) || (op == `FPC_OP_ARRAY);
    endfunction : fpc_is_flash_op

    ////////////////////////////////////////////////////////////////////////////////
    // State

    fpc_pkg::fpc_state_s st_reg;
    fpc_pkg::fpc_state_s st_next;
    logic arm_reg;
    logic arm_next;
    logic arm_rst_n;

    // The arm bit is the only control bit that a device reset touches.
    assign arm_rst_n = RSTN & POR_N;

    logic setup;
    logic access;
    logic [15:0] base;
    logic [1:0] kind;
    logic hit_ctl;
    logic hit_key;
    logic hit_tgt;
    logic hit_dat;
    logic hit_src;
    logic mapped;
    logic [31:0] ctl_view;
    logic [31:0] ctl_new;
    logic [31:0] rd_val;
    logic start;
    logic [3:0] run_op;

    ////////////////////////////////////////////////////////////////////////////////
    // Address decode

    always_comb begin
        base = {PADDR[15:4], 4'h0};
        kind = PADDR[3:2];
        hit_ctl = (base == `FPC_OFF_CONTROL) && (PADDR[1:0] == 2'h0);
        hit_tgt = (base == `FPC_OFF_TARGET) && (PADDR[1:0] == 2'h0);
        // Only the control and address registers carry aliases.
        hit_key = (PADDR == `FPC_OFF_KEY);
        hit_dat = (PADDR == `FPC_OFF_DATA);
        hit_src = (PADDR == `FPC_OFF_SOURCE);
        mapped = hit_ctl | hit_tgt | hit_key | hit_dat | hit_src;
        setup = PSEL & ~PENABLE;
        access = PSEL & PENABLE & st_reg.rsp.ready;
    end

    always_comb begin
        ctl_view = `FPC_CONTROL_RESET;
        ctl_view[`FPC_BIT_TRIGGER] = st_reg.trigger;
        ctl_view[`FPC_BIT_ARM] = arm_reg;
        ctl_view[`FPC_BIT_OPFAULT] = st_reg.op_fault;
        ctl_view[`FPC_BIT_UVFAULT] = st_reg.uv_fault;
        ctl_view[`FPC_BIT_UVLIVE] = st_reg.uv_live;
        ctl_view[`FPC_OPSEL_MSB:0] = st_reg.op_sel;
        ctl_new = fpc_alias(kind, ctl_view, PWDATA);
        rd_val = 32'h0000_0000;
        if (hit_ctl) begin
            rd_val = ctl_view;
        end else if (hit_tgt) begin
            rd_val = st_reg.target;
        end else if (hit_dat) begin
            rd_val = st_reg.pdata;
        end else if (hit_src) begin
            rd_val = st_reg.source;
        end
        // A key read falls through to zero.
        if (hit_key) begin
            rd_val = 32'h0000_0000;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        st_next = st_reg;
        arm_next = arm_reg;
        start = 1'b0;
        run_op = st_reg.cmd.op;

        // Zero-wait APB: the answer is prepared during the setup cycle.
        st_next.rsp.ready = setup;
        st_next.rsp.slverr = setup & ~mapped;
        st_next.rsp.rdata = (setup & ~PWRITE) ? rd_val : 32'h0000_0000;
        st_next.cmd.req = 1'b0;

        // Unlock tracking; any completed access that is not part of it cancels it.
        if (access) begin
            if (PWRITE && hit_key && PWDATA == `FPC_KEY_FIRST) begin
                st_next.unlock = fpc_pkg::UNL_FIRST;
            end else if (PWRITE && hit_key && PWDATA == `FPC_KEY_SECOND &&
                         st_reg.unlock == fpc_pkg::UNL_FIRST) begin
                st_next.unlock = fpc_pkg::UNL_READY;
            end else begin
                st_next.unlock = fpc_pkg::UNL_NONE;
            end
        end

        if (access && PWRITE) begin
            if (hit_ctl) begin
                arm_next = ctl_new[`FPC_BIT_ARM];
                if (!arm_reg) begin
                    st_next.op_sel = ctl_new[`FPC_OPSEL_MSB:0];
                end
                // Trigger may rise only armed, unlocked and idle; clearing is hardware's.
                if (ctl_new[`FPC_BIT_TRIGGER] && !st_reg.trigger && arm_reg &&
                    st_reg.unlock == fpc_pkg::UNL_READY) begin
                    start = 1'b1;
                end
            end
            if (hit_tgt) begin
                st_next.target = fpc_alias(kind, st_reg.target, PWDATA);
            end
            if (hit_dat) begin
                st_next.pdata = PWDATA;
            end
            if (hit_src) begin
                st_next.source = PWDATA;
            end
        end

        // The detector is powered only while armed; the live bit tracks it.
        st_next.uv_live = arm_reg & UV_DETECT;

        unique case (st_reg.fsm)
            fpc_pkg::FSM_IDLE: begin
                if (start) begin
                    st_next.trigger = 1'b1;
                    run_op = st_reg.op_sel;
                    st_next.cmd.op = st_reg.op_sel;
                    st_next.fsm = fpc_pkg::FSM_FINISH;
                    if (st_reg.op_sel == `FPC_OP_NONE) begin
                        st_next.op_fault = 1'b0;
                        st_next.uv_fault = 1'b0;
                    end else if (fpc_is_flash_op(st_reg.op_sel)) begin
                        if (WP_TARGET || (st_reg.op_sel == `FPC_OP_ARRAY && WP_ANY)) begin
                            // Protected region: nothing is touched, the attempt fails.
                            st_next.op_fault = 1'b1;
                        end else begin
                            st_next.cmd.req = 1'b1;
                            st_next.cmd.addr = fpc_align(st_reg.op_sel, st_reg.target);
                            st_next.cmd.data = st_reg.pdata;
                            st_next.cmd.src = st_reg.source;
                            st_next.fsm = fpc_pkg::FSM_RUN;
                        end
                    end
                    // Codes 0010, 0110 and the reserved codes complete with no effect.
                end
            end
            fpc_pkg::FSM_RUN: begin
                if (arm_reg && UV_DETECT) begin
                    st_next.uv_fault = 1'b1;
                end
                if (FL_DONE) begin
                    if (FL_FAIL || (arm_reg && UV_DETECT)) begin
                        st_next.op_fault = 1'b1;
                    end
                    st_next.fsm = fpc_pkg::FSM_FINISH;
                end
            end
            fpc_pkg::FSM_FINISH: begin
                st_next.trigger = 1'b0;
                st_next.fsm = fpc_pkg::FSM_IDLE;
            end
            default: begin
                st_next.trigger = 1'b0;
                st_next.fsm = fpc_pkg::FSM_IDLE;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Registers

    // Everything but the arm bit survives a device reset; data only clears on power-on.
    always_ff @(posedge CLK or negedge POR_N) begin
        if (!POR_N) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    always_ff @(posedge CLK or negedge arm_rst_n) begin
        if (!arm_rst_n) begin
            arm_reg <= 1'b0;
        end else begin
            arm_reg <= arm_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Outputs

    assign PREADY = st_reg.rsp.ready;
    assign PSLVERR = st_reg.rsp.slverr;
    assign PRDATA = st_reg.rsp.rdata;
    assign FL_CMD = st_reg.cmd;
    assign UV_DETECT_EN = arm_reg;
    assign BUSY = st_reg.trigger;

endmodule : fpc_top

// [test/fpc_props.sv]
`timescale 1ns/1ns
module fpc_props (
    // Clock and resets
    input wire logic CLK,
    input wire logic RSTN,
    input wire logic POR_N,
    // Register bus
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [15:0] PADDR,
    input wire logic PREADY,
    input wire logic PSLVERR,
    input wire logic [31:0] PRDATA,
    // Engine and status
    input wire fpc_pkg::fpc_cmd_s FL_CMD,
    input wire logic FL_DONE,
    input wire logic WP_TARGET,
    input wire logic WP_ANY,
    input wire logic UV_DETECT_EN,
    input wire logic BUSY
);
    default clocking @(posedge CLK); endclocking
    default disable iff (!POR_N || !RSTN);
    //////////////////////////////
    arm_gate_a: assert property ($rose(BUSY) |-> $past(UV_DETECT_EN))
        else $error("trigger rose without arm");
    req_start_a: assert property (FL_CMD.req |-> $rose(BUSY))
        else $error("command without trigger");
    req_pulse_a: assert property (FL_CMD.req |=> !FL_CMD.req)
        else $error("command request too long");
    done_clear_a: assert property (BUSY && FL_DONE && !FL_CMD.req |-> ##[1:2] !BUSY)
        else $error("trigger not cleared");
    key_zero_a: assert property (PREADY && !PWRITE && PADDR == 16'hF410 |-> PRDATA == 32'h0)
        else $error("key read not zero");
    protect_a: assert property (FL_CMD.req |-> !$past(WP_TARGET) || FL_CMD.op == 4'h5)
        else $error("protected region started");
    array_wp_a: assert property (FL_CMD.req && FL_CMD.op == 4'h5 |-> !$past(WP_ANY) && FL_CMD.addr == 32'h0)
        else $error("array erase wrong");
    arm_write_a: assert property ($rose(UV_DETECT_EN) |-> $past(PREADY) && $past(PWRITE))
        else $error("arm rose without write");
    ready_a: assert property (PSEL && !PENABLE |=> PREADY)
        else $error("no ready after setup");
    slverr_a: assert property (PREADY && PADDR == 16'hF414 |-> PSLVERR)
        else $error("unmapped alias accepted");
    cover property (FL_CMD.req);
    cover property (PSLVERR);
    cover property ($fell(BUSY));
endmodule : fpc_props
bind fpc_top fpc_props u_props (.CLK, .RSTN, .POR_N, .PSEL, .PENABLE, .PWRITE, .PADDR,
    .PREADY, .PSLVERR, .PRDATA, .FL_CMD, .FL_DONE, .WP_TARGET, .WP_ANY, .UV_DETECT_EN, .BUSY);

// [test/tb_flash_program_controller.sv]
`timescale 1ns/1ns
`include "fpc_cfg.svh"
module tb_flash_program_controller;
    logic CLK = 1'b0;
    logic RSTN = 1'b0;
    logic POR_N = 1'b0;
    logic PSEL = 1'b0;
    logic PENABLE = 1'b0;
    logic PWRITE = 1'b0;
    logic [15:0] PADDR = 16'h0000;
    logic [31:0] PWDATA = 32'h0;
    logic FL_DONE = 1'b0;
    logic FL_FAIL = 1'b0;
    logic WP_TARGET = 1'b0;
    logic WP_ANY = 1'b0;
    logic UV_DETECT = 1'b0;
    logic PREADY, PSLVERR, BUSY, UV_DETECT_EN, e;
    logic [31:0] PRDATA, q;
    fpc_pkg::fpc_cmd_s FL_CMD;
    int n_fail = 0;
    int tests_run = 0;
    int cyc = 0;
    fpc_top u_dut (.CLK(CLK), .RSTN(RSTN), .POR_N(POR_N), .PSEL(PSEL), .PENABLE(PENABLE),
        .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
        .PRDATA(PRDATA), .FL_CMD(FL_CMD), .FL_DONE(FL_DONE), .FL_FAIL(FL_FAIL),
        .WP_TARGET(WP_TARGET), .WP_ANY(WP_ANY), .UV_DETECT(UV_DETECT),
        .UV_DETECT_EN(UV_DETECT_EN), .BUSY(BUSY));
    initial begin
        forever #25 CLK = ~CLK;
    end
    //////////////////////////////
    task final_report;
        $display("comparisons %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : final_report
    task chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // Reads PREADY before the edge's own updates land, so this is the sampled value.
    task apb(input logic w, input logic [15:0] a, input logic [31:0] d);
        @(posedge CLK);
        PSEL <= 1'b1;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= d;
        @(posedge CLK);
        PENABLE <= 1'b1;
        do @(posedge CLK); while (PREADY !== 1'b1);
        q = PRDATA;
        e = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
    endtask : apb
    task rd(input logic [15:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(q, exp);
    endtask : rd
    // Operation select only moves while arm is low, so arm is dropped around it.
    task go(input logic [3:0] op);
        apb(1'b1, 16'hF404, 32'h4000);
        apb(1'b1, 16'hF400, {28'h0, op});
        apb(1'b1, 16'hF408, 32'h4000);
        apb(1'b1, 16'hF410, `FPC_KEY_FIRST);
        apb(1'b1, 16'hF410, `FPC_KEY_SECOND);
        apb(1'b1, 16'hF400, {16'h0, 12'hC00, op});
        @(posedge CLK);
    endtask : go
    task done(input logic f);
        FL_DONE <= 1'b1;
        FL_FAIL <= f;
        repeat (20) begin
            @(posedge CLK);
            if (BUSY === 1'b0) break;
        end
        chk({31'h0, BUSY}, 32'h0);
        FL_DONE <= 1'b0;
    endtask : done
    task note(input string s);
        $display("test %s finished", s);
    endtask : note
    always @(posedge CLK) begin
        cyc++;
        if (cyc == 4000) begin
            n_fail++;
            final_report;
        end
    end
    //////////////////////////////
    initial begin
        repeat (8) @(posedge CLK);
        POR_N <= 1'b1;
        RSTN <= 1'b1;
        for (int i = 0; i < 5; i++) rd(16'hF400 + 16'(i * 16), 32'h0);
        apb(1'b1, 16'hF400, 32'h1);
        apb(1'b1, 16'hF408, 32'h4000);
        apb(1'b1, 16'hF400, 32'h4003);
        rd(16'hF400, 32'h4001);
        UV_DETECT <= 1'b1;
        rd(16'hF400, 32'h4801);
        UV_DETECT <= 1'b0;
        rd(16'hF400, 32'h4001);
        apb(1'b1, 16'hF400, 32'hC001);
        @(posedge CLK);
        chk({31'h0, BUSY}, 32'h0);
        apb(1'b1, 16'hF410, `FPC_KEY_FIRST);
        rd(16'hF410, 32'h0);
        apb(1'b1, 16'hF410, `FPC_KEY_SECOND);
        apb(1'b1, 16'hF400, 32'hC001);
        @(posedge CLK);
        chk({31'h0, BUSY}, 32'h0);
        note("gating");
        apb(1'b1, 16'hF420, 32'h100);
        apb(1'b1, 16'hF430, 32'hA5A5A5A5);
        go(4'h1);
        chk({26'h0, BUSY, FL_CMD.req, FL_CMD.op}, 32'h31);
        chk(FL_CMD.addr ^ FL_CMD.data, 32'hA5A5A4A5);
        done(1'b0);
        rd(16'hF400, 32'h4001);
        apb(1'b1, 16'hF440, 32'h2000);
        apb(1'b1, 16'hF420, 32'h200);
        go(4'h3);
        chk(FL_CMD.src ^ FL_CMD.addr, 32'h2200);
        UV_DETECT <= 1'b1;
        done(1'b1);
        UV_DETECT <= 1'b0;
        rd(16'hF400, 32'h7003);
        go(4'h0);
        rd(16'hF400, 32'h4000);
        WP_TARGET <= 1'b1;
        go(4'h4);
        chk({30'h0, BUSY, FL_CMD.req}, 32'h2);
        WP_TARGET <= 1'b0;
        rd(16'hF400, 32'h6004);
        WP_ANY <= 1'b1;
        go(4'h5);
        chk({30'h0, BUSY, FL_CMD.req}, 32'h2);
        WP_ANY <= 1'b0;
        apb(1'b1, 16'hF420, 32'h3000);
        go(4'h5);
        chk(FL_CMD.addr, 32'h0);
        done(1'b0);
        go(4'h4);
        chk(FL_CMD.addr, 32'h3000);
        done(1'b0);
        for (int i = 0; i < 3; i++) begin
            go(i == 0 ? 4'h2 : 4'h5 + 4'(i));
            chk({30'h0, BUSY, FL_CMD.req}, 32'h2);
        end
        note("operations");
        apb(1'b1, 16'hF420, 32'hF0);
        apb(1'b1, 16'hF42C, 32'hFF);
        rd(16'hF420, 32'h0F);
        apb(1'b0, 16'hF414, 32'h0);
        chk({31'h0, e}, 32'h1);
        apb(1'b1, 16'hF430, 32'h5A);
        RSTN <= 1'b0;
        @(posedge CLK);
        RSTN <= 1'b1;
        rd(16'hF400, 32'h2007);
        rd(16'hF430, 32'h5A);
        POR_N <= 1'b0;
        @(posedge CLK);
        POR_N <= 1'b1;
        rd(16'hF430, 32'h0);
        note("resets");
        final_report;
    end
endmodule : tb_flash_program_controller
